// >>> rtl/lpm_pkg.sv
// shared constants, types and register map of the low power mode controller
package lpm_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register map, byte addresses on the control bus
   localparam int LPM_AW = 4;
   localparam logic [3:0] LPM_OFS_CTRL = 4'h0;
   localparam logic [3:0] LPM_OFS_CMD = 4'h4;
   localparam logic [3:0] LPM_OFS_STATUS = 4'h8;
   localparam logic [3:0] LPM_OFS_FLAGCLR = 4'hc;

   // control register fields
   localparam int LPM_CTRL_IE = 0;
   localparam int LPM_CTRL_TIMER_A_MODE_TOP_BIT = 1;
   localparam int LPM_CTRL_LOW_SPEED_ON_FLAG = 2;
   localparam int LPM_CTRL_MISC = 3;
   localparam logic [4:0] LPM_CTRL_RESET = 5'h00;

   // command register fields, write one to execute
   localparam int LPM_CMD_SBY = 0;
   localparam int LPM_CMD_STOP = 1;

   // status and flag-clear register fields
   localparam int LPM_ST_MODE = 0;
   localparam int LPM_ST_F0 = 4;
   localparam int LPM_ST_FTA = 5;
   localparam int LPM_ST_SETTLE = 6;

   localparam logic [1:0] LPM_RESP_OKAY = 2'h0;
   localparam logic [1:0] LPM_RESP_SLVERR = 2'h2;

   // build option: sub-active mode present
   localparam logic LPM_SUBACTIVE_OPTION = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // timing: settling interval in subclock ticks, rounded up
   localparam longint LPM_SUB_CLK_HZ = 32768;
   localparam longint LPM_TRC_NS = 122070;
   localparam int LPM_TRC_TICKS = int'((LPM_TRC_NS * LPM_SUB_CLK_HZ + 64'd999999999) / 64'd1000000000);
   localparam logic [7:0] LPM_HALF_FRAME_BASE = 8'(LPM_TRC_TICKS);

   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      LPM_ACTIVE,
      LPM_STANDBY,
      LPM_STOP,
      LPM_WATCH,
      LPM_SUBACTIVE
   } lpm_mode_e;

   typedef struct packed {
      logic [7:0] cnt;
      logic frame_strobe;
      logic half_strobe;
   } lpm_tb_state_s;

   typedef struct packed {
      logic [1:0] i0_sync;
      logic i0_prev;
      logic [1:0] sub_sync;
      logic sub_prev;
      logic [1:0] rst_sync;
      lpm_mode_e mode;
      logic ie;
      logic timer_a_mode_top_bit;
      logic low_speed_on_flag;
      logic [1:0] misc;
      logic f0;
      logic fta;
      logic i0_seen;
      logic ta_seen;
      logic settle;
      logic aw_ok;
      logic [3:0] aw_addr;
      logic w_ok;
      logic [31:0] w_data;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic sub_tick;
      logic cpu_clk_en;
      logic per_clk_en;
      logic tbase_clk_en;
      logic main_osc_en;
      logic cpu_on_subclk;
      logic io_hold;
      logic io_hiz;
      logic periph_reset;
      logic cpu_reset;
      logic ram_hold;
      logic irq_accept;
      logic irq_held;
      logic serial_irq_out;
   } lpm_state_s;

endpackage : lpm_pkg

// >>> rtl/lpm_time_base.sv
// interrupt frame time base clocked by subclock ticks
`timescale 1ns/1ps
`default_nettype none

module lpm_time_base
   import lpm_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic run,
   input wire logic sub_tick,
   input wire logic [1:0] misc,
   output logic frame_strobe,
   output logic half_strobe
);

   lpm_tb_state_s s;
   lpm_tb_state_s next_s;

   // half frame grows by powers of two with the misc code
   function automatic logic [7:0] half_len(input logic [1:0] code);
      half_len = LPM_HALF_FRAME_BASE << code;
   endfunction : half_len

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s = s;
      next_s.frame_strobe = 1'b0;
      next_s.half_strobe = 1'b0;
      if (!run) begin
         next_s.cnt = 8'h00;
      end else if (sub_tick) begin
         // this counter alone, stepped by subclock ticks, acts as the frame source
         if (s.cnt == 8'((half_len(misc) << 1) - 8'h01)) begin
            next_s.cnt = 8'h00;
            next_s.frame_strobe = 1'b1;
         end else begin
            next_s.cnt = 8'(s.cnt + 8'h01);
         end
         if (s.cnt == 8'(half_len(misc) - 8'h01)) begin
            next_s.half_strobe = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign frame_strobe = s.frame_strobe;
   assign half_strobe = s.half_strobe;

endmodule : lpm_time_base

`default_nettype wire

// >>> rtl/lpm_mode_ctrl.sv
// low power mode controller: mode sequencing, clock gating, wake logic, axi4-lite registers
`timescale 1ns/1ps
`default_nettype none

module lpm_mode_ctrl
   import lpm_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic ext_irq_zero_pin,
   input wire logic sub_osc_in,
   input wire logic reset_pin_n,
   input wire logic timer_a_ovf,
   input wire logic periph_irq,
   input wire logic serial_irq_in,
   input wire logic [LPM_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [LPM_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic cpu_clk_en,
   output logic per_clk_en,
   output logic tbase_clk_en,
   output logic main_osc_en,
   output logic cpu_on_subclk,
   output logic io_hold,
   output logic io_hiz,
   output logic periph_reset,
   output logic cpu_reset,
   output logic ram_hold,
   output logic irq_accept,
   output logic irq_held,
   output logic serial_irq_out,
   output logic [2:0] mode_out
);

   lpm_state_s s;
   lpm_state_s next_s;
   logic frame_strobe;
   logic half_strobe;

   localparam lpm_state_s LPM_STATE_RESET = '{
      mode: LPM_ACTIVE, awready: 1'b1, wready: 1'b1, arready: 1'b1,
      cpu_clk_en: 1'b1, per_clk_en: 1'b1, tbase_clk_en: 1'b1, main_osc_en: 1'b1,
      // synchronisers start at the idle pin levels, so no false reset or edge follows reset
      rst_sync: 2'b11, i0_sync: 2'b11, i0_prev: 1'b1,
      default: '0};

   function automatic logic low_mode(input lpm_mode_e m);
      low_mode = (m == LPM_WATCH) || (m == LPM_SUBACTIVE);
   endfunction : low_mode

   function automatic logic mapped(input logic [LPM_AW-1:0] a);
      mapped = (a == LPM_OFS_CTRL) || (a == LPM_OFS_CMD) ||
               (a == LPM_OFS_STATUS) || (a == LPM_OFS_FLAGCLR);
   endfunction : mapped

   ////////////////////////////////////////////////////////////////////////
   lpm_time_base u_time_base (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .run(low_mode(s.mode) || s.settle),
      .sub_tick(s.sub_tick),
      .misc(s.misc),
      .frame_strobe(frame_strobe),
      .half_strobe(half_strobe)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic pin_rst;
      logic fall;
      logic low;
      logic do_wr;
      logic cmd_sby;
      logic cmd_stop;
      logic clr_f0;
      logic clr_fta;
      logic set_f0;
      logic set_fta;
      logic wake;
      logic [31:0] rd;
      pin_rst = 1'b0;
      fall = 1'b0;
      low = 1'b0;
      do_wr = 1'b0;
      cmd_sby = 1'b0;
      cmd_stop = 1'b0;
      clr_f0 = 1'b0;
      clr_fta = 1'b0;
      set_f0 = 1'b0;
      set_fta = 1'b0;
      wake = 1'b0;
      rd = 32'h0000_0000;
      next_s = s;

      // pins pass two flops before anything looks at them
      next_s.i0_sync = {s.i0_sync[0], ext_irq_zero_pin};
      next_s.i0_prev = s.i0_sync[1];
      next_s.sub_sync = {s.sub_sync[0], sub_osc_in};
      next_s.sub_prev = s.sub_sync[1];
      next_s.sub_tick = s.sub_sync[1] & ~s.sub_prev;
      next_s.rst_sync = {s.rst_sync[0], reset_pin_n};
      pin_rst = ~s.rst_sync[1];
      fall = s.i0_prev & ~s.i0_sync[1];
      low = low_mode(s.mode);

      ////////////////////////////////////////////////////////////////////
      // bus write: address and data taken in either order
      if (s_axi_awvalid && s.awready) begin
         next_s.aw_ok = 1'b1;
         next_s.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready) begin
         next_s.w_ok = 1'b1;
         next_s.w_data = s_axi_wdata;
         // lanes other than byte 0 carry only reserved bits
         if (!s_axi_wstrb[0]) begin
            next_s.w_data = 32'h0000_0000;
         end
      end
      if (s.aw_ok && s.w_ok && !s.bvalid) begin
         do_wr = 1'b1;
         next_s.aw_ok = 1'b0;
         next_s.w_ok = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = mapped(s.aw_addr) ? LPM_RESP_OKAY : LPM_RESP_SLVERR;
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (do_wr && (s.aw_addr == LPM_OFS_CTRL)) begin
         next_s.ie = s.w_data[LPM_CTRL_IE];
         next_s.timer_a_mode_top_bit = s.w_data[LPM_CTRL_TIMER_A_MODE_TOP_BIT];
         next_s.low_speed_on_flag = s.w_data[LPM_CTRL_LOW_SPEED_ON_FLAG] & LPM_SUBACTIVE_OPTION;
         next_s.misc = s.w_data[LPM_CTRL_MISC+:2];
      end
      // commands only mean something while an instruction clock runs
      if (do_wr && (s.aw_addr == LPM_OFS_CMD) && s.cpu_clk_en) begin
         cmd_sby = s.w_data[LPM_CMD_SBY];
         cmd_stop = s.w_data[LPM_CMD_STOP];
      end
      if (do_wr && (s.aw_addr == LPM_OFS_FLAGCLR)) begin
         clr_f0 = s.w_data[LPM_ST_F0];
         clr_fta = s.w_data[LPM_ST_FTA];
      end

      // bus read
      if (s_axi_arvalid && s.arready) begin
         case (s_axi_araddr)
            LPM_OFS_CTRL: rd[4:0] = {s.misc, s.low_speed_on_flag, s.timer_a_mode_top_bit, s.ie};
            LPM_OFS_STATUS: begin
               rd[LPM_ST_MODE+:3] = s.mode;
               rd[LPM_ST_F0] = s.f0;
               rd[LPM_ST_FTA] = s.fta;
               rd[LPM_ST_SETTLE] = s.settle;
            end
            default: rd = 32'h0000_0000;
         endcase
         next_s.rdata = rd;
         next_s.rresp = mapped(s_axi_araddr) ? LPM_RESP_OKAY : LPM_RESP_SLVERR;
         next_s.rvalid = 1'b1;
      end else if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end

      ////////////////////////////////////////////////////////////////////
      // wake sources
      if (low) begin
         // edges and overflows wait for the next strobe
         if (fall && !s.settle) begin
            next_s.i0_seen = 1'b1;
         end
         if (timer_a_ovf) begin
            next_s.ta_seen = 1'b1;
         end
         if (frame_strobe) begin
            set_f0 = next_s.i0_seen;
            set_fta = next_s.ta_seen;
            next_s.i0_seen = 1'b0;
            next_s.ta_seen = 1'b0;
         end
      end else if (s.mode != LPM_STOP) begin
         set_f0 = fall && !s.settle;
         set_fta = timer_a_ovf;
         next_s.i0_seen = 1'b0;
         next_s.ta_seen = 1'b0;
      end
      // an event in the clearing cycle survives
      next_s.f0 = (s.f0 & ~clr_f0) | set_f0;
      next_s.fta = (s.fta & ~clr_fta) | set_fta;
      wake = set_f0 | set_fta;

      ////////////////////////////////////////////////////////////////////
      case (s.mode)
         LPM_ACTIVE: begin
            if (cmd_stop) begin
               next_s.mode = s.timer_a_mode_top_bit ? LPM_WATCH : LPM_STOP;
            end else if (cmd_sby) begin
               next_s.mode = LPM_STANDBY;
            end
         end
         LPM_STANDBY: begin
            // any request brings the cpu back; enable decides service
            if (wake || periph_irq || s.f0 || s.fta) begin
               next_s.mode = LPM_ACTIVE;
            end
         end
         LPM_STOP: begin
            next_s.mode = LPM_STOP; // only the reset pin leaves
         end
         LPM_WATCH: begin
            if (wake) begin
               if (s.low_speed_on_flag && LPM_SUBACTIVE_OPTION) begin
                  next_s.mode = LPM_SUBACTIVE;
               end else begin
                  next_s.mode = LPM_ACTIVE;
                  next_s.settle = 1'b1;
               end
            end
         end
         LPM_SUBACTIVE: begin
            if (cmd_stop || cmd_sby) begin
               next_s.mode = LPM_WATCH;
            end
         end
         default: next_s.mode = LPM_ACTIVE;
      endcase
      // half a frame lets the main oscillator settle
      if (s.settle && half_strobe) begin
         next_s.settle = 1'b0;
      end
      if (pin_rst) begin
         next_s.mode = LPM_ACTIVE;
         next_s.settle = 1'b0;
         next_s.i0_seen = 1'b0;
         next_s.ta_seen = 1'b0;
         // a device reset also returns control bits and flags to their reset state
         next_s.ie = 1'b0;
         next_s.timer_a_mode_top_bit = 1'b0;
         next_s.low_speed_on_flag = 1'b0;
         next_s.misc = 2'b00;
         next_s.f0 = 1'b0;
         next_s.fta = 1'b0;
      end

      ////////////////////////////////////////////////////////////////////
      // clock gates and holds follow the next mode
      next_s.main_osc_en = (next_s.mode == LPM_ACTIVE) || (next_s.mode == LPM_STANDBY);
      next_s.cpu_clk_en = ((next_s.mode == LPM_ACTIVE) && !next_s.settle) ||
                          (next_s.mode == LPM_SUBACTIVE);
      next_s.per_clk_en = next_s.main_osc_en;
      next_s.tbase_clk_en = next_s.mode != LPM_STOP;
      next_s.cpu_on_subclk = next_s.mode == LPM_SUBACTIVE;
      next_s.io_hold = (next_s.mode == LPM_STANDBY) || (next_s.mode == LPM_WATCH);
      next_s.io_hiz = next_s.mode == LPM_STOP;
      next_s.periph_reset = next_s.mode == LPM_STOP;
      // working registers are lost, ram is not cleared
      next_s.cpu_reset = (next_s.mode == LPM_STOP) || pin_rst;
      next_s.ram_hold = next_s.mode != LPM_SUBACTIVE && next_s.mode != LPM_ACTIVE;
      next_s.irq_accept = next_s.cpu_clk_en && next_s.ie &&
                          (next_s.f0 || next_s.fta || periph_irq);
      // without the enable the request waits and code continues
      next_s.irq_held = (next_s.f0 || next_s.fta || periph_irq) && !next_s.irq_accept;
      next_s.serial_irq_out = serial_irq_in && !low_mode(next_s.mode) &&
                              (next_s.mode != LPM_STOP);

      // one write and one read under way at a time
      next_s.awready = !next_s.aw_ok && !next_s.bvalid;
      next_s.wready = !next_s.w_ok && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= LPM_STATE_RESET;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign cpu_clk_en = s.cpu_clk_en;
   assign per_clk_en = s.per_clk_en;
   assign tbase_clk_en = s.tbase_clk_en;
   assign main_osc_en = s.main_osc_en;
   assign cpu_on_subclk = s.cpu_on_subclk;
   assign io_hold = s.io_hold;
   assign io_hiz = s.io_hiz;
   assign periph_reset = s.periph_reset;
   assign cpu_reset = s.cpu_reset;
   assign ram_hold = s.ram_hold;
   assign irq_accept = s.irq_accept;
   assign irq_held = s.irq_held;
   assign serial_irq_out = s.serial_irq_out;
   assign mode_out = s.mode;

endmodule : lpm_mode_ctrl

`default_nettype wire

// >>> tb/lpm_mode_ctrl_assertions.sv
// port-level checks of the mode controller
`timescale 1ns/1ps
`default_nettype none

module lpm_checker
   import lpm_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic reset_pin_n,
   input wire logic [2:0] mode_out,
   input wire logic cpu_clk_en,
   input wire logic per_clk_en,
   input wire logic tbase_clk_en,
   input wire logic main_osc_en,
   input wire logic cpu_on_subclk,
   input wire logic io_hold,
   input wire logic io_hiz,
   input wire logic periph_reset,
   input wire logic cpu_reset,
   input wire logic ram_hold,
   input wire logic irq_accept,
   input wire logic irq_held,
   input wire logic serial_irq_out
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////////////////
   // gates move with the mode; only a mode held over two edges is judged
   a_active_clocks: assert property (
      mode_out == 3'h0 && $stable(mode_out) |-> per_clk_en && main_osc_en && !io_hiz)
      else $error("active mode without main clocks");
   a_standby_gates: assert property (
      mode_out == 3'h1 && $stable(mode_out) |-> !cpu_clk_en && per_clk_en && main_osc_en && io_hold && ram_hold)
      else $error("standby gating wrong");
   a_stop_gates: assert property (
      mode_out == 3'h2 && $stable(mode_out) |-> io_hiz && periph_reset && cpu_reset && ram_hold
         && !main_osc_en && !cpu_clk_en && !per_clk_en && !tbase_clk_en)
      else $error("stop gating wrong");
   a_watch_gates: assert property (
      mode_out == 3'h3 && $stable(mode_out) |-> !cpu_clk_en && !per_clk_en && tbase_clk_en && io_hold)
      else $error("watch gating wrong");
   a_sub_clocking: assert property (
      mode_out == 3'h4 && $stable(mode_out) |-> cpu_on_subclk && cpu_clk_en && !per_clk_en)
      else $error("sub-active clocking wrong");
   a_stop_exit: assert property (
      $past(mode_out) == 3'h2 && mode_out != 3'h2 |-> mode_out == 3'h0
         && (!$past(reset_pin_n, 2) || !$past(reset_pin_n, 3) || !$past(reset_pin_n, 4)))
      else $error("stop left without the reset pin");
   a_standby_exit: assert property (
      $past(mode_out) == 3'h1 && mode_out != 3'h1 |-> mode_out == 3'h0)
      else $error("standby left to a mode other than active");
   a_watch_exit: assert property (
      $past(mode_out) == 3'h3 && mode_out != 3'h3 |-> mode_out == 3'h0 || mode_out == 3'h4)
      else $error("watch left to an illegal mode");
   a_pin_reset: assert property (
      !reset_pin_n [*5] |-> mode_out == 3'h0 && cpu_reset)
      else $error("reset pin did not force active");
   a_serial_quiet: assert property (
      mode_out inside {3'h2, 3'h3, 3'h4} && $stable(mode_out) |-> !serial_irq_out)
      else $error("serial interrupt leaked in a low mode");
   a_irq_exclusive: assert property (
      irq_accept |-> cpu_clk_en && !irq_held)
      else $error("request both accepted and held");
endmodule : lpm_checker

`default_nettype wire

// >>> tb/lpm_wake_src.sv
// reset pin, subclock crystal and wake sources facing the mode controller
`timescale 1ns/1ps
`default_nettype none

module lpm_wake_src
   import lpm_pkg::*;
#(
   parameter int SUB_HALF = 4
)
(
   input wire logic aclk,
   output logic sub_osc_in,
   output logic reset_pin_n,
   output logic ext_irq_zero_pin,
   output logic timer_a_ovf
);
   int sub_cnt;

   initial begin
      sub_cnt = 0;
      sub_osc_in <= 1'b0;
      reset_pin_n <= 1'b1;
      ext_irq_zero_pin <= 1'b1;
      timer_a_ovf <= 1'b0;
   end

   // the crystal runs in every mode, so the subclock never pauses
   always @(posedge aclk) begin
      sub_cnt <= (sub_cnt == SUB_HALF - 1) ? 0 : sub_cnt + 1;
      if (sub_cnt == SUB_HALF - 1) begin
         sub_osc_in <= ~sub_osc_in;
      end
   end

   // held past the settling interval with margin, never shorter
   task automatic hw_reset();
      @(posedge aclk);
      reset_pin_n <= 1'b0;
      repeat (LPM_TRC_TICKS * SUB_HALF * 2 + 8) @(posedge aclk);
      reset_pin_n <= 1'b1;
   endtask : hw_reset

   task automatic pin_fall();
      @(posedge aclk);
      ext_irq_zero_pin <= 1'b0;
      repeat (8) @(posedge aclk);
      ext_irq_zero_pin <= 1'b1;
   endtask : pin_fall

   task automatic ta_pulse();
      @(posedge aclk);
      ext_irq_zero_pin <= 1'b1;
      timer_a_ovf <= 1'b1;
      @(posedge aclk);
      timer_a_ovf <= 1'b0;
   endtask : ta_pulse
endmodule : lpm_wake_src

`default_nettype wire

// >>> tb/test_low_power_mode_control.sv
// self-checking bench of the low power mode controller
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("FAIL at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module test_low_power_mode_control
   import lpm_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn, ce, ext_irq_zero_pin, sub_osc_in, reset_pin_n, timer_a_ovf, periph_irq, serial_irq_in;
   logic [LPM_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic cpu_clk_en, per_clk_en, tbase_clk_en, main_osc_en, cpu_on_subclk, io_hold, io_hiz;
   logic periph_reset, cpu_reset, ram_hold, irq_accept, irq_held, serial_irq_out;
   logic [2:0] mode_out;
   int n_mismatch = 0;
   int n_checks = 0;
   int n;
   int exp_n;

   always #4 aclk = ~aclk;

   lpm_mode_ctrl i_dut (.*);
   lpm_wake_src u_src (.*);

   ////////////////////////////////////////////////////////////////////////
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (s_axi_awready !== 1'b1);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (s_axi_wready !== 1'b1);
            s_axi_wvalid <= 1'b0;
         end
      join
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      `CHK(s_axi_bresp, LPM_RESP_OKAY)
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      `CHK(s_axi_rresp, LPM_RESP_OKAY)
      s_axi_rready <= 1'b0;
   endtask : axi_rd

   task automatic wait_mode(input logic [2:0] m);
      for (int i = 0; i < 4000 && mode_out !== m; i++) @(posedge aclk);
      `CHK(mode_out, m)
   endtask : wait_mode

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////////////////////////////////////
   initial begin
      aresetn <= 1'b0;
      ce <= 1'b1;
      periph_irq <= 1'b0;
      serial_irq_in <= 1'b0;
      s_axi_awaddr <= 4'h0;
      s_axi_araddr <= 4'h0;
      s_axi_wdata <= 32'h0;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b0;
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(LPM_OFS_CTRL);
      `CHK(rd[4:0], LPM_CTRL_RESET)
      axi_rd(LPM_OFS_STATUS);
      `CHK(rd, 32'h0)
      `CHK({cpu_clk_en, per_clk_en, main_osc_en}, 3'h7)
      // standby with interrupts disabled: request held, then taken once enabled
      axi_wr(LPM_OFS_CMD, 32'h1);
      wait_mode(3'h1);
      repeat (3) @(posedge aclk);
      `CHK({cpu_clk_en, per_clk_en}, 2'h1)
      // with the clock enable low the request must not move the mode
      ce <= 1'b0;
      periph_irq <= 1'b1;
      repeat (8) @(posedge aclk);
      `CHK(mode_out, 3'h1)
      ce <= 1'b1;
      wait_mode(3'h0);
      repeat (3) @(posedge aclk);
      `CHK({irq_held, irq_accept}, 2'h2)
      axi_wr(LPM_OFS_CTRL, 32'h1);
      repeat (3) @(posedge aclk);
      `CHK({irq_held, irq_accept}, 2'h1)
      periph_irq <= 1'b0;
      // stop: wake sources refused, only the reset pin ends it
      axi_wr(LPM_OFS_CTRL, 32'h0);
      axi_wr(LPM_OFS_CMD, 32'h2);
      wait_mode(3'h2);
      periph_irq <= 1'b1;
      u_src.ta_pulse();
      repeat (40) @(posedge aclk);
      `CHK(mode_out, 3'h2)
      `CHK({io_hiz, periph_reset, main_osc_en}, 3'h6)
      periph_irq <= 1'b0;
      u_src.hw_reset();
      wait_mode(3'h0);
      // watch wake into active for every frame period, both wake sources
      for (int m = 0; m < 4; m++) begin
         axi_wr(LPM_OFS_FLAGCLR, 32'h30);
         axi_wr(LPM_OFS_CTRL, 32'(m * 8 + 2));
         axi_wr(LPM_OFS_CMD, 32'h2);
         wait_mode(3'h3);
         serial_irq_in <= 1'b1;
         repeat (4) @(posedge aclk);
         `CHK(serial_irq_out, 1'b0)
         if (m % 2 == 1) begin
            u_src.ta_pulse();
         end else begin
            u_src.pin_fall();
         end
         wait_mode(3'h0);
         n = 0;
         while (cpu_clk_en !== 1'b1 && n < 5000) begin
            @(posedge aclk);
            n++;
         end
         exp_n = (int'(LPM_HALF_FRAME_BASE) << m) * 8;
         `CHK(n >= exp_n - 8 && n <= exp_n + 8, 1'b1)
         axi_rd(LPM_OFS_STATUS);
         `CHK(rd[5:4], (m % 2 == 1) ? 2'h2 : 2'h1)
         serial_irq_in <= 1'b0;
      end
      // watch wake into sub-active, then back to watch by the standby op
      axi_wr(LPM_OFS_FLAGCLR, 32'h30);
      axi_wr(LPM_OFS_CTRL, 32'h6);
      axi_wr(LPM_OFS_CMD, 32'h2);
      wait_mode(3'h3);
      u_src.ta_pulse();
      wait_mode(3'h4);
      repeat (4) @(posedge aclk);
      `CHK(cpu_on_subclk, 1'b1)
      axi_rd(LPM_OFS_STATUS);
      `CHK(rd[6:0], 7'h24)
      axi_wr(LPM_OFS_FLAGCLR, 32'h30);
      axi_wr(LPM_OFS_CMD, 32'h1);
      wait_mode(3'h3);
      u_src.hw_reset();
      wait_mode(3'h0);
      axi_rd(LPM_OFS_CTRL);
      `CHK(rd[4:0], LPM_CTRL_RESET)
      end_of_test();
   end

   initial begin
      repeat (60000) @(posedge aclk);
      n_mismatch++;
      end_of_test();
   end
endmodule : test_low_power_mode_control

bind lpm_mode_ctrl lpm_checker i_chk (.*);

`default_nettype wire
